/* tb/tb.sv */
// self-checking bench for the receive error injection stage
`timescale 1ns/100ps
`default_nettype none
module tb;
	import lin_err_inj_pkg::*;
	logic        hclk, hresetn, hsel, hwrite, pwm, lin, tick;
	logic        hreadyout, irq, mon, line_out, ck_out, tmode, hr_s;
	logic        hresp, lpb, rxp, ck_in;
	logic [1:0]  htrans, psi;
	logic [2:0]  txs;
	logic [31:0] haddr, hwdata, hrdata, rd;
	rx_bit_t     rx_in, rx_out;
	sync_meas_t  s_in, s_out;
	int          errors, comparisons;

	lin_sci_error_injection i_dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata),
		.irq(irq), .protected_write_mode(pwm), .lin_mode(lin),
		.bit_tick(tick), .rx_in(rx_in), .rx_line_in(1'b1),
		.checksum_kind_in(ck_in), .sync_in(s_in), .rx_out(rx_out),
		.monitor_bit(mon), .rx_line_out(line_out),
		.checksum_kind_out(ck_out), .sync_out(s_out), .io_test_mode(tmode),
		.loopback_enable(lpb), .rx_pin_enable(rxp),
		.pin_sample_invert(psi), .tx_shift(txs));

	// clock and the ready level seen by the master at the next edge
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	always @(negedge hclk) hr_s = hreadyout;

	task give_verdict;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : give_verdict

	task cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : cmp

	// one single-word transfer; read data lands in rd
	task bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		@(posedge hclk);
		while (!hr_s) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge hclk);
		while (!hr_s) @(posedge hclk);
		rd = hrdata;
	endtask : bus

	// one received bit strobe, returns once the output is registered
	task send(input logic v, input logic stp, input logic par, input logic bk);
		@(posedge hclk);
		rx_in <= '{1'b1, v, stp, par, bk};
		@(posedge hclk);
		rx_in <= '0;
		#1;
	endtask : send

	task meas(input logic [15:0] w);
		@(posedge hclk);
		s_in <= '{1'b1, w};
		@(posedge hclk);
		s_in <= '0;
		#1;
	endtask : meas

	task set_lin(input logic v);
		@(posedge hclk);
		lin <= v;
	endtask : set_lin

	task t_key;
		cmp(mon, 1'b1, "monitor reset");
		cmp(line_out, 1'b1, "line reset");
		bus(1'b0, 32'h0, 32'h0);
		cmp(rd, 32'h0, "ctrl reset");
		cmp(hresp, 1'b0, "okay response");
		bus(1'b1, 32'h0, 32'hfffffaff);
		bus(1'b0, 32'h0, 32'h0);
		cmp(rd, 32'hf71f0003, "key unprotected");
		cmp(tmode, 1'b0, "mode unprotected");
		cmp({lpb, rxp, psi, txs}, 7'h00, "fields gated");
		pwm <= 1'b1;
		bus(1'b1, 32'h0, 32'hfffffaff);
		bus(1'b0, 32'h0, 32'h0);
		cmp(rd, 32'hf71f0a03, "reserved bits");
		cmp(tmode, 1'b1, "mode on");
		cmp({lpb, rxp, psi, txs}, 7'h7f, "fields on");
		bus(1'b1, 32'h10, 32'hffffffff);
		bus(1'b0, 32'h10, 32'h0);
		cmp(rd, 32'h0, "unmapped");
	endtask : t_key

	task t_lin;
		bus(1'b1, 32'h0, 32'h04000000);
		send(1'b1, 1'b1, 1'b0, 1'b0);
		cmp(rx_out.value, 1'b1, "gated stop");
		set_lin(1'b1);
		bus(1'b1, 32'h0, 32'h80000a00);
		send(1'b0, 1'b0, 1'b0, 1'b0);
		cmp(mon, 1'b1, "bit forced");
		bus(1'b1, 32'h0, 32'h40000a00);
		send(1'b0, 1'b0, 1'b0, 1'b1);
		cmp(mon, 1'b1, "break tx bit");
		send(1'b0, 1'b0, 1'b0, 1'b0);
		cmp(mon, 1'b0, "normal bit");
		bus(1'b1, 32'h0, 32'h20000a00);
		repeat (2) @(posedge hclk);
		#1;
		cmp(ck_out, 1'b1, "checksum kind");
		ck_in <= 1'b1;
		repeat (2) @(posedge hclk);
		#1;
		cmp(ck_out, 1'b0, "checksum kind high");
		bus(1'b1, 32'h0, 32'h10000a00);
		@(posedge hclk);
		#1;
		cmp(ck_out, 1'b1, "checksum plain");
		meas(16'd100);
		cmp(s_out, {1'b1, 16'd100}, "sync first");
		meas(16'd100);
		cmp(s_out, {1'b1, 16'd116}, "sync second");
		bus(1'b1, 32'h0, 32'h04000a00);
		send(1'b1, 1'b1, 1'b0, 1'b0);
		cmp(rx_out.value, 1'b0, "stop zeroed");
		send(1'b1, 1'b0, 1'b0, 1'b0);
		cmp(rx_out.value, 1'b1, "data kept");
	endtask : t_lin

	task t_sci;
		set_lin(1'b0);
		bus(1'b1, 32'h0, 32'h02000a00);
		send(1'b1, 1'b0, 1'b1, 1'b0);
		cmp(rx_out.value, 1'b0, "parity flip");
		set_lin(1'b1);
		send(1'b1, 1'b0, 1'b1, 1'b0);
		cmp(rx_out.value, 1'b1, "parity lin");
	endtask : t_sci

	// break hold, masked event, interrupt raise and clear by status read
	task t_break;
		set_lin(1'b0);
		bus(1'b0, 32'h4, 32'h0);
		bus(1'b1, 32'h8, 32'h20);
		bus(1'b1, 32'h0, 32'h01000a00);
		send(1'b1, 1'b1, 1'b0, 1'b0);
		cmp(rx_out.value, 1'b0, "break stop");
		@(posedge hclk);
		#1;
		cmp(irq, 1'b0, "masked event");
		for (int i = 0; i < 10; i++) begin
			cmp(line_out, 1'b0, "line held");
			@(posedge hclk);
			tick <= 1'b1;
			@(posedge hclk);
			tick <= 1'b0;
			#1;
		end
		repeat (3) @(posedge hclk);
		#1;
		cmp(line_out, 1'b1, "line back");
		cmp(irq, 1'b1, "irq raised");
		bus(1'b0, 32'h4, 32'h0);
		cmp(rd & 32'h20, 32'h20, "break status");
		@(posedge hclk);
		#1;
		cmp(irq, 1'b0, "irq cleared");
		bus(1'b0, 32'h4, 32'h0);
		cmp(rd & 32'h20, 32'h0, "status cleared");
	endtask : t_break

	// main sequence
	initial begin
		errors = 0;
		comparisons = 0;
		hresetn = 1'b0;
		{hsel, hwrite, pwm, lin, tick, ck_in} = '0;
		htrans = 2'b00;
		haddr = 32'h0;
		hwdata = 32'h0;
		rx_in = '0;
		s_in = '0;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		t_key;
		t_lin;
		t_sci;
		t_break;
		give_verdict;
	end

	// watchdog against a hung handshake
	initial begin
		#100000;
		errors++;
		$display("MISMATCH %0t watchdog expired", $time);
		give_verdict;
	end
endmodule : tb
`default_nettype wire

/* verilog/break_hold_timer.sv */
// timer that holds the internal receive input low for a break
`timescale 1ns/100ps
`default_nettype none
`include "lin_err_inj_defines.svh"

module break_hold_timer #(
	parameter int BITS = `IOT_BREAK_BITS
) (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic start,
	input  wire logic bit_tick,
	output var  logic active,
	output var  logic done
);

	logic [7:0] count;
	wire        last_tick = active && bit_tick && (count == 8'(BITS - 1));

	// count bit times while holding; a start during a hold is ignored
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			active <= 1'b0;
			count  <= 8'h00;
			done   <= 1'b0;
		end else begin
			done <= last_tick;
			if (!active && start) begin
				active <= 1'b1;
				count  <= 8'h00;
			end else if (last_tick) begin
				active <= 1'b0;
			end else if (active && bit_tick) begin
				count <= count + 8'h01;
			end
		end
	end

endmodule : break_hold_timer
`default_nettype wire

/* verilog/lin_err_inj_defines.svh */
// offsets, field positions, reset values and counts of the error injector
`ifndef LIN_ERR_INJ_DEFINES_SVH
`define LIN_ERR_INJ_DEFINES_SVH

// register byte offsets
`define IOT_OFS_CTRL     8'h00
`define IOT_OFS_STAT     8'h04
`define IOT_OFS_MASK     8'h08

// control field positions
`define IOT_BIT_BITERR   31
`define IOT_BIT_PHYSERR  30
`define IOT_BIT_CKSERR   29
`define IOT_BIT_SYNCERR  28
`define IOT_BIT_FRMERR   26
`define IOT_BIT_PARERR   25
`define IOT_BIT_BRKERR   24
`define IOT_KEY_MSB      11
`define IOT_KEY_LSB      8

// enable key value and writable bits outside the key
`define IOT_KEY_ON       4'ha
`define IOT_CTRL_WMASK   32'hf71f0003
`define IOT_KEY_MASK     32'h00000f00
`define IOT_CTRL_RESET   32'h00000000

// status and mask bits
`define IOT_EVT_W        6
`define IOT_EVT_BIT      0
`define IOT_EVT_PHYS     1
`define IOT_EVT_FRAME    2
`define IOT_EVT_PARITY   3
`define IOT_EVT_SYNC     4
`define IOT_EVT_BREAK    5

// timing counts
`define IOT_BREAK_BITS   10
`define IOT_SYNC_SKEW    16'h0010

`endif

/* verilog/lin_err_inj_pkg.sv */
// types shared by the error injector files
package lin_err_inj_pkg;

	// one received bit from the pin sampler
	typedef struct packed {
		logic valid;       // one-cycle strobe
		logic value;       // sampled bit level
		logic is_stop;     // bit is a stop bit
		logic is_parity;   // bit is a parity bit
		logic in_break_tx; // received while sending the sync break
	} rx_bit_t;

	// one sync field bit width measurement
	typedef struct packed {
		logic        valid;
		logic [15:0] width;
	} sync_meas_t;

	// bus slave states
	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_WRITE = 4'b0010,
		ST_RWAIT = 4'b0100,
		ST_RDONE = 4'b1000
	} bus_state_t;

endpackage : lin_err_inj_pkg

/* verilog/lin_sci_error_injection.sv */
// error injection stage between the receive sampler and the checkers
//
// Our own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "lin_err_inj_defines.svh"

// Functional notes
// RULE1: LIN mode bit error enable forces bits to one toward the bit monitor.
// RULE2: LIN physical bus enable forces bits received during break send to one.
// RULE3: LIN checksum enable inverts checksum kind given to the checksum check.
// RULE4: LIN sync enable skews sync bit widths so the consistency check fails.
// RULE5: frame error enable forces received stop bits to zero.
// RULE6: compatible mode parity enable inverts each received parity bit.
// RULE7: compatible break enable zeroes stop bit, then holds input low 10 bits.
// RULE8: reserved bits 27 and 23-21 read zero and ignore writes.
// RULE9: every control field acts only while the test mode is active.
// RULE10: key readable always, writable in protected mode; value A enables mode.
// RULE11: clear enables pass data unaltered; all enables reset to zero.
module lin_sci_error_injection
	import lin_err_inj_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output var  logic [31:0] hrdata,
	output var  logic        irq,
	input  wire logic        protected_write_mode,
	input  wire logic        lin_mode,
	input  wire logic        bit_tick,
	input  wire rx_bit_t     rx_in,
	input  wire logic        rx_line_in,
	input  wire logic        checksum_kind_in,
	input  wire sync_meas_t  sync_in,
	output var  rx_bit_t     rx_out,
	output var  logic        monitor_bit,
	output var  logic        rx_line_out,
	output var  logic        checksum_kind_out,
	output var  sync_meas_t  sync_out,
	output var  logic        io_test_mode,
	output var  logic        loopback_enable,
	output var  logic        rx_pin_enable,
	output var  logic [1:0]  pin_sample_invert,
	output var  logic [2:0]  tx_shift
);

	bus_state_t            state;
	bus_state_t            next_state;
	logic [7:0]            addr;
	logic [31:0]           ctrl;
	logic [`IOT_EVT_W-1:0] stat;
	logic [`IOT_EVT_W-1:0] mask;
	logic                  sync_alt;
	logic                  brk_active;
	logic                  brk_done;

	// address phase decode
	wire take      = hsel && hready && htrans[1];
	wire wr_commit = (state == ST_WRITE);
	wire rd_load   = (state == ST_RWAIT);
	wire sel_ctrl  = (addr == `IOT_OFS_CTRL);
	wire sel_stat  = (addr == `IOT_OFS_STAT);
	wire sel_mask  = (addr == `IOT_OFS_MASK);

	// write data merge: key only under protected write, reserved never
	wire [31:0] wr_mask = `IOT_CTRL_WMASK
		| (protected_write_mode ? `IOT_KEY_MASK : 32'h0); // RULE10 RULE8
	wire [31:0] next_ctrl = (ctrl & ~wr_mask) | (hwdata & wr_mask);

	// read data selection
	wire [31:0] rd_word =
		sel_ctrl ? ctrl :
		sel_stat ? {26'h0, stat} :
		sel_mask ? {26'h0, mask} : 32'h0;

	// mode qualification
	wire mode_on = (ctrl[`IOT_KEY_MSB:`IOT_KEY_LSB] == `IOT_KEY_ON); // RULE10
	wire lin_on  = mode_on && lin_mode;  // RULE9
	wire sci_on  = mode_on && !lin_mode; // RULE9

	// per-bit injection conditions
	wire inj_bit   = lin_on && ctrl[`IOT_BIT_BITERR]; // RULE1
	wire inj_phys  = lin_on && ctrl[`IOT_BIT_PHYSERR]
		&& rx_in.in_break_tx; // RULE2
	wire inj_ck    = lin_on && ctrl[`IOT_BIT_CKSERR]; // RULE3
	wire inj_sync  = lin_on && ctrl[`IOT_BIT_SYNCERR]; // RULE4
	wire inj_frame = mode_on && ctrl[`IOT_BIT_FRMERR]
		&& rx_in.is_stop; // RULE5
	wire inj_brk   = sci_on && ctrl[`IOT_BIT_BRKERR]
		&& rx_in.is_stop; // RULE7
	wire inj_par   = sci_on && ctrl[`IOT_BIT_PARERR]
		&& rx_in.is_parity; // RULE6

	// modified values, untouched when nothing is injected
	wire next_mon   = rx_in.value | inj_bit | inj_phys; // RULE1 RULE2 RULE11
	wire next_value = (rx_in.value & ~(inj_frame | inj_brk))
		^ inj_par; // RULE5 RULE6 RULE7 RULE11
	wire [15:0] next_width = sync_in.width
		+ ((inj_sync && sync_alt) ? `IOT_SYNC_SKEW : 16'h0); // RULE4
	wire rx_bit_t next_rx = '{rx_in.valid, next_value, rx_in.is_stop,
		rx_in.is_parity, rx_in.in_break_tx}; // RULE11

	// events that set sticky status bits
	wire v = rx_in.valid;
	wire [`IOT_EVT_W-1:0] evt = {
		brk_done,
		inj_sync && sync_in.valid,
		v && inj_par,
		v && (inj_frame || inj_brk),
		v && inj_phys,
		v && inj_bit
	};

	// bus state sequencing
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE, ST_WRITE, ST_RDONE: begin
				if (take && hwrite) begin
					next_state = ST_WRITE;
				end else if (take) begin
					next_state = ST_RWAIT;
				end else begin
					next_state = ST_IDLE;
				end
			end
			ST_RWAIT: begin
				next_state = ST_RDONE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// bus handshake: reads take one wait state
	assign hreadyout = (state != ST_RWAIT);
	assign hresp     = 1'b0;

	// bus state, captured address and read data
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state  <= ST_IDLE;
			addr   <= 8'h00;
			hrdata <= 32'h0;
		end else begin
			state <= next_state;
			if (take) begin
				addr <= {haddr[7:2], 2'b00};
			end
			if (rd_load) begin
				hrdata <= rd_word; // RULE8
			end
		end
	end

	// control and mask registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl <= `IOT_CTRL_RESET; // RULE11
			mask <= '0;
		end else if (wr_commit) begin
			if (sel_ctrl) begin
				ctrl <= next_ctrl; // RULE8 RULE10
			end
			if (sel_mask) begin
				mask <= hwdata[`IOT_EVT_W-1:0];
			end
		end
	end

	// sticky status: read clears, a new event wins over the clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stat <= '0;
			irq  <= 1'b0;
		end else begin
			stat <= ((rd_load && sel_stat) ? '0 : stat) | evt;
			irq  <= |((((rd_load && sel_stat) ? '0 : stat) | evt) & mask);
		end
	end

	// receive path stage, one cycle of latency
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_out            <= '0;
			monitor_bit       <= 1'b1;
			checksum_kind_out <= 1'b0;
			sync_out          <= '0;
			sync_alt          <= 1'b0;
			rx_line_out       <= 1'b1;
		end else begin
			rx_out            <= next_rx;
			monitor_bit       <= next_mon;
			checksum_kind_out <= checksum_kind_in ^ inj_ck; // RULE3
			sync_out.valid    <= sync_in.valid;
			sync_out.width    <= next_width;
			rx_line_out       <= rx_line_in & ~brk_active; // RULE7
			if (!inj_sync) begin
				sync_alt <= 1'b0;
			end else if (sync_in.valid) begin
				sync_alt <= ~sync_alt; // RULE4
			end
		end
	end

	// break hold after the zeroed stop bit
	break_hold_timer #(
		.BITS (`IOT_BREAK_BITS)
	) u_break_hold (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.start    (v && inj_brk), // RULE7
		.bit_tick (bit_tick),
		.active   (brk_active),
		.done     (brk_done)
	);

	// control fields presented to the rest of the module
	always_comb begin
		io_test_mode      = mode_on;
		loopback_enable   = mode_on && ctrl[1]; // RULE9
		rx_pin_enable     = mode_on && ctrl[0]; // RULE9
		pin_sample_invert = mode_on ? ctrl[20:19] : 2'b00;
		tx_shift          = mode_on ? ctrl[18:16] : 3'b000;
	end

	// checks on the injection behaviour
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	chk_bit_force: assert property ( // RULE1
		rx_in.valid && lin_mode && io_test_mode && ctrl[31] |=> monitor_bit)
		else $error("bit error injection did not force one");

	chk_phys_force: assert property ( // RULE2
		rx_in.valid && rx_in.in_break_tx && lin_mode && io_test_mode
		&& ctrl[30] |=> monitor_bit)
		else $error("physical bus injection did not force one");

	chk_cksum_invert: assert property ( // RULE3
		io_test_mode && lin_mode && ctrl[29]
		|=> checksum_kind_out != $past(checksum_kind_in))
		else $error("checksum kind not inverted");

	chk_sync_skew: assert property ( // RULE4
		sync_in.valid && io_test_mode && lin_mode && ctrl[28] && sync_alt
		|=> sync_out.width == $past(sync_in.width) + `IOT_SYNC_SKEW)
		else $error("second sync width not skewed");

	chk_stop_zero: assert property ( // RULE5
		rx_in.valid && rx_in.is_stop && io_test_mode && ctrl[26]
		|=> rx_out.valid && !rx_out.value)
		else $error("stop bit not forced to zero");

	chk_parity_flip: assert property ( // RULE6
		rx_in.valid && rx_in.is_parity && !rx_in.is_stop && !lin_mode
		&& io_test_mode && ctrl[25]
		|=> rx_out.value == !$past(rx_in.value))
		else $error("parity bit not inverted");

	chk_break_hold: assert property ( // RULE7
		$rose(brk_active) |=> !rx_line_out [*2])
		else $error("receive input not held low for break");

	// bit ticks seen while the break hold keeps the line low
	logic [7:0] held_ticks;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			held_ticks <= 8'h00;
		end else if (!brk_active) begin
			held_ticks <= 8'h00;
		end else if (bit_tick) begin
			held_ticks <= held_ticks + 8'h01;
		end
	end

	chk_break_len: assert property ( // RULE7
		$fell(brk_active) |-> held_ticks == 8'(`IOT_BREAK_BITS))
		else $error("break hold did not last ten bit times");

	chk_reserved_zero: assert property ( // RULE8
		state == ST_RWAIT && sel_ctrl
		|=> hrdata[27] == 1'b0 && hrdata[23:21] == 3'b000)
		else $error("reserved control bits read nonzero");

	chk_mode_gate: assert property ( // RULE9
		rx_in.valid && !io_test_mode
		|=> monitor_bit == $past(rx_in.value)
		&& rx_out == $past(rx_in))
		else $error("bit altered outside test mode");

	chk_key_protect: assert property ( // RULE10
		wr_commit && sel_ctrl && !protected_write_mode
		|=> $stable(ctrl[11:8]))
		else $error("key changed without protected write");

	cov_bit_inject: cover property (v && inj_bit ##1 monitor_bit);
	cov_break_done: cover property ($fell(brk_active) ##1 rx_line_out);
	cov_stat_read:  cover property (rd_load && sel_stat && |stat ##1 irq);
	cov_sync_skew:  cover property (sync_in.valid && inj_sync && sync_alt);

endmodule : lin_sci_error_injection
`default_nettype wire
